// >>> hw/dcc_defines.vh
// Register map, field positions, reset values and mode codes of the comparator control
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH

// Byte offsets of the APB registers
`define DCC_OFS_CTRL        8'h00
`define DCC_OFS_REQ         8'h04
`define DCC_OFS_ENA         8'h08
`define DCC_OFS_INTCTL      8'h0C
`define DCC_OFS_DIR         8'h10
`define DCC_OFS_PORT        8'h14

// Control register fields
`define DCC_CTRL_OUT2       7
`define DCC_CTRL_OUT1       6
`define DCC_CTRL_INV2       5
`define DCC_CTRL_INV1       4
`define DCC_CTRL_CIS        3
`define DCC_CTRL_MODE_HI    2
`define DCC_CTRL_MODE_LO    0

// Flag, enable and interrupt-control bit positions
`define DCC_REQ_FLAG        6
`define DCC_ENA_FLAG        6
`define DCC_INT_GLOBAL      7
`define DCC_INT_PERIPH      6

// Direction bits of the two comparator output pins
`define DCC_DIR_PIN1        1
`define DCC_DIR_PIN2        2

// Reset values
`define DCC_RST_CTRL        8'h07
`define DCC_RST_DIR         8'hFF

// Mode codes
`define DCC_MODE_OFF        3'h7
`define DCC_MODE_MUX_REF    3'h6
`define DCC_MODE_PIN_OUT    3'h3

`endif

// >>> hw/dcc_top.v
// Dual comparator control, status, pin routing and change-flag logic
// Functional notes
// R1: Status bit is 1 when positive input exceeds negative; inversion bit reverses it.
// R2: Control bits 5 and 4 invert comparator two and one outputs.
// R3: Status bits 7 and 6 are read-only; writes there do nothing.
// R4: Three-bit mode field picks one of eight configurations; direction bits set pins.
// R5: In mode 110 input switch picks F5/F3 when 1, F6/F4 when 0.
// R6: Internal reference drives both positive inputs, only in mode 110.
// R7: Pin output carries raw unsynchronized comparator output when pin routing enabled.
// R8: Direction bits still act as output enable of the two routed pins.
// R9: Change flag is set whenever either comparator output changes.
// R10: Software keeps its own copy of status bits to see which changed.
// R11: Flag clears only by writing 0; writing 1 sets it.
// R12: Request reaches processor only with flag enable, peripheral and global enables.
// R13: Flag still sets while any enable is clear; only forwarding is blocked.
// R14: A change coinciding with a control read may miss setting the flag.
// R15: Any control register read or write ends the mismatch condition.
// R16: Persisting mismatch keeps setting the flag until control is accessed.
// R17: Software should disable the interrupt while changing the mode field.
// R18: Port data read returns 0 for every pin configured analog.
// R19: Reset returns control register to mode 111, comparators off.
// R20: Comparators keep working in sleep; enabled change wakes; control preserved.
// R21: Latch of adjusted outputs reloads on control access; mismatch requests flag set.
// R22: Status path is two-flop synchronized; pin path stays unsynchronized.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dcc_defines.vh"

// Register map, one word per register, data in the low byte:
//   0x00 control: status 7:6 (read-only), inversion 5:4, switch 3,
//        mode 2:0; any access reloads the mismatch latch
//   0x04 change flag in bit 6; 0x08 its enable in bit 6
//   0x0C global enable bit 7, peripheral enable bit 6
//   0x10 direction, 1 = input; 0x14 synchronized port levels
// Unmapped addresses answer with an error and ignore writes.

module dcc_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        first_compare_raw,
    input  wire        second_compare_raw,
    input  wire [7:0]  port_f_in,
    input  wire [7:0]  analog_pin_mask,
    output wire        port_f_pin1_out,
    output wire        port_f_pin2_out,
    output reg         port_f_pin1_oe,
    output reg         port_f_pin2_oe,
    output reg  [1:0]  compare_enable,
    output reg         ref_to_positive,
    output reg         neg_input_switch,
    output reg         compare_irq_request,
    output reg         wake_request
);

    reg [7:0] ctrl;
    reg       flag;
    reg       flag_enable;
    reg       global_enable;
    reg       periph_enable;
    reg [7:0] direction;
    reg [1:0] sync1;
    reg [1:0] sync2;
    reg       next_flag;
    reg [7:0] port_s1;
    reg [7:0] port_s2;
    reg [1:0] latched;
    reg [31:0] next_rdata;
    reg        next_err;

    wire [2:0] mode = ctrl[`DCC_CTRL_MODE_HI:`DCC_CTRL_MODE_LO];
    wire [1:0] inv  = {ctrl[`DCC_CTRL_INV2], ctrl[`DCC_CTRL_INV1]};
    wire       pin_route = (mode == `DCC_MODE_PIN_OUT);

    // Access phase: the one edge where a transfer really completes
    wire xfer     = psel & penable & pready;
    wire wr       = xfer & pwrite;
    wire ctrl_acc = xfer & (paddr == `DCC_OFS_CTRL); // R15

    // Adjusted, synchronized outputs feed status and mismatch
    // Any difference from the latch is a pending, unacknowledged change
    wire [1:0] adjusted = sync2 ^ inv; // R1 R2 R22
    wire       mismatch = (adjusted != latched); // R21

    // Flag write strobe, kept apart from the mismatch set path
    wire       wr_req   = wr & (paddr == `DCC_OFS_REQ); // R11

    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `DCC_OFS_CTRL) || (a == `DCC_OFS_REQ) ||
                        (a == `DCC_OFS_ENA) || (a == `DCC_OFS_INTCTL) ||
                        (a == `DCC_OFS_DIR) || (a == `DCC_OFS_PORT);
        end
    endfunction

    // Mode decode shared by the reference and input-switch routing
    function is_mux_ref;
        input [2:0] m;
        begin
            is_mux_ref = (m == `DCC_MODE_MUX_REF); // R6
        end
    endfunction

    // Pin path is raw on purpose: no clock delay to the outside world.
    // Glitches near the threshold reach the pin unfiltered.
    assign port_f_pin1_out = (first_compare_raw ^ inv[0]) & pin_route;  // R7
    assign port_f_pin2_out = (second_compare_raw ^ inv[1]) & pin_route; // R7

    // Comparator synchronizer; first stage read only by the second.
    // Costs two cycles of status latency but keeps metastability away
    // from the mismatch detector, which fans out to the flag.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
        end else begin
            sync1 <= {second_compare_raw, first_compare_raw}; // R22
            sync2 <= sync1;
        end
    end

    // Port level synchronizer for the digital read path
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_s1 <= 8'h00;
            port_s2 <= 8'h00;
        end else begin
            port_s1 <= port_f_in;
            port_s2 <= port_s1;
        end
    end

    // Software-visible control, enable and direction registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl          <= `DCC_RST_CTRL; // R19
            flag_enable   <= 1'b0;
            global_enable <= 1'b0;
            periph_enable <= 1'b0;
            direction     <= `DCC_RST_DIR;
        end else if (wr) begin
            case (paddr)
                `DCC_OFS_CTRL: begin
                    // Status positions stay out of the stored value
                    ctrl <= {2'h0, pwdata[5:0]}; // R2 R3 R4
                end
                `DCC_OFS_ENA: begin
                    flag_enable <= pwdata[`DCC_ENA_FLAG];
                end
                `DCC_OFS_INTCTL: begin
                    global_enable <= pwdata[`DCC_INT_GLOBAL];
                    periph_enable <= pwdata[`DCC_INT_PERIPH];
                end
                `DCC_OFS_DIR: begin
                    direction <= pwdata[7:0];
                end
                default: begin
                    ctrl <= ctrl;
                end
            endcase
        end
    end

    // Latch reloads on every control access, read or write, ending the
    // mismatch. A write takes the pre-write adjusted value, so changing
    // an inversion bit raises the flag again on the next cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched <= 2'h0;
        end else if (ctrl_acc) begin
            latched <= adjusted; // R15 R21
        end
    end

    // Next flag value: hardware set wins over a software clear.
    // The mismatch is checked every cycle, including the cycle of a
    // control access, so a coinciding change is never lost; this is
    // stricter than the allowed miss and costs nothing.
    always @* begin
        next_flag = flag;
        if (wr_req) begin
            next_flag = pwdata[`DCC_REQ_FLAG]; // R11
        end
        if (mismatch) begin
            next_flag = 1'b1; // R9 R13 R14 R16
        end
    end

    // Change flag register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    // Request forwarding through the three-level enable chain
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_irq_request <= 1'b0;
            wake_request        <= 1'b0;
        end else begin
            compare_irq_request <= flag & flag_enable & periph_enable &
                                   global_enable; // R12
            // Sleep wake needs only the local enable; clock keeps running
            wake_request        <= flag & flag_enable; // R20
        end
    end

    // Output enables of the routed pins; a set direction bit means input
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_f_pin1_oe <= 1'b0;
            port_f_pin2_oe <= 1'b0;
        end else begin
            port_f_pin1_oe <= pin_route & ~direction[`DCC_DIR_PIN1]; // R8
            port_f_pin2_oe <= pin_route & ~direction[`DCC_DIR_PIN2]; // R8
        end
    end

    // Analog routing controls; registered so the pads see clean levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_enable   <= 2'h0;
            ref_to_positive  <= 1'b0;
            neg_input_switch <= 1'b0;
        end else begin
            compare_enable   <= (mode == `DCC_MODE_OFF) ? 2'h0 : 2'h3; // R4
            ref_to_positive  <= is_mux_ref(mode); // R6
            neg_input_switch <= is_mux_ref(mode) & ctrl[`DCC_CTRL_CIS]; // R5
        end
    end

    // Read data mux; analog pins read as zero on the port
    // Upper bits of every word read as zero
    always @* begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        case (paddr)
            `DCC_OFS_CTRL: begin
                next_rdata[7:0] = {adjusted[1], adjusted[0], ctrl[5:0]}; // R3
            end
            `DCC_OFS_REQ: begin
                next_rdata[`DCC_REQ_FLAG] = flag;
            end
            `DCC_OFS_ENA: begin
                next_rdata[`DCC_ENA_FLAG] = flag_enable;
            end
            `DCC_OFS_INTCTL: begin
                next_rdata[`DCC_INT_GLOBAL] = global_enable;
                next_rdata[`DCC_INT_PERIPH] = periph_enable;
            end
            `DCC_OFS_DIR: begin
                next_rdata[7:0] = direction;
            end
            `DCC_OFS_PORT: begin
                next_rdata[7:0] = port_s2 & ~analog_pin_mask; // R18
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    // APB handshake: one wait state so read data comes from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= next_err | ~is_mapped(paddr);
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Read data stands only with pready, zero otherwise; write cycles
    // return zero so no stale register value leaks onto the bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && penable && !pready && !pwrite) begin
            prdata <= next_rdata;
        end else begin
            prdata <= 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// >>> dv/dcc_properties.sv
// Port-level properties of the dual comparator control block
`timescale 1ns/10ps
`default_nettype none
module dcc_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        first_compare_raw,
    input wire logic        port_f_pin1_out,
    input wire logic        port_f_pin1_oe,
    input wire logic [1:0]  compare_enable,
    input wire logic        ref_to_positive,
    input wire logic        neg_input_switch,
    input wire logic        compare_irq_request,
    input wire logic        wake_request
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // First cycle of an access phase
    sequence s_access_start;
        psel && $rose(penable);
    endsequence
    // Bus answer: one wait state, one-cycle pulse, data only with it
    a_one_wait: assert property (s_access_start |=> pready)
        else $error("no ready after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than a cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error response outside completion");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data not zero while idle");
    // Pin follows the raw input in the same cycle, registers quiet
    a_pin_raw: assert property ($changed(first_compare_raw)
        && port_f_pin1_oe && !$past(pready) |-> $changed(port_f_pin1_out))
        else $error("routed pin missed a raw change");
    a_chain_order: assert property (compare_irq_request |-> wake_request)
        else $error("request forwarded without local enable");
    a_ref_enable: assert property (ref_to_positive |-> compare_enable == 2'h3)
        else $error("reference routed while comparators off");
    a_switch_mode: assert property (neg_input_switch |-> ref_to_positive)
        else $error("input switch active outside mux mode");
    // Flag only clears on a bus write
    a_flag_holds: assert property (wake_request && !psel
        && !$past(psel) |=> wake_request)
        else $error("flag dropped without software write");
endmodule
`default_nettype wire

// >>> dv/dcc_analog_model.sv
// Analog front end: two comparators fed by modelled input levels
`timescale 1ns/10ps
`default_nettype none
module dcc_analog_model (
    input  wire logic [7:0] pos_one,
    input  wire logic [7:0] neg_one,
    input  wire logic [7:0] pos_two,
    input  wire logic [7:0] neg_two,
    output logic            raw_one,
    output logic            raw_two
);
    // High only when the positive input is strictly above the negative
    assign raw_one = pos_one > neg_one;
    assign raw_two = pos_two > neg_two;
endmodule
`default_nettype wire

// >>> dv/dual_comparator_control_tb.sv
// Self-checking bench for the dual comparator control block
`timescale 1ns/10ps
`default_nettype none
`include "dcc_defines.vh"
module dual_comparator_control_tb;
    logic        pclk = '0, presetn = '0, psel = '0, penable = '0;
    logic        pwrite = '0, err, e1, e2;
    logic [7:0]  paddr = '0, port_f_in = '0, analog_pin_mask = '0;
    logic [7:0]  p1 = '0, n1 = '0, p2 = '0, n2 = '0;
    logic [31:0] pwdata = '0, rd;
    wire  [31:0] prdata;
    wire  [1:0]  compare_enable;
    wire         pready, pslverr, first_compare_raw, second_compare_raw;
    wire         port_f_pin1_out, port_f_pin2_out, port_f_pin1_oe;
    wire         port_f_pin2_oe, ref_to_positive, neg_input_switch;
    wire         compare_irq_request, wake_request;
    int          fail_count = 0, comparisons = 0;
    dcc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .first_compare_raw,
        .second_compare_raw, .port_f_in, .analog_pin_mask,
        .port_f_pin1_out, .port_f_pin2_out, .port_f_pin1_oe,
        .port_f_pin2_oe, .compare_enable, .ref_to_positive,
        .neg_input_switch, .compare_irq_request, .wake_request);
    dcc_analog_model i_front (.pos_one(p1), .neg_one(n1), .pos_two(p2),
        .neg_two(n2), .raw_one(first_compare_raw),
        .raw_two(second_compare_raw));
    // Free-running bus clock
    always #12.5 pclk = ~pclk;
    task automatic complete_run;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One transfer; an idle edge follows so psel is never driven twice
    task automatic apb(input logic wr, input logic [7:0] a, d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            fail_count++;
            complete_run;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        void'($urandom(81));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `DCC_OFS_CTRL, 8'h00);
        chk(rd, 32'h00000007);
        apb(0, 8'h1C, 8'h00);
        chk({31'h0, err}, 32'h00000001);
        // Every inversion setting with pins routed and driven
        apb(1, `DCC_OFS_DIR, 8'hF9);
        for (int i = 0; i < 4; i++) begin
            {p1, n1, p2, n2} <= 32'($urandom);
            apb(1, `DCC_OFS_CTRL, {2'b11, i[1:0], 4'h3});
            repeat (4) @(posedge pclk);
            e1 = (p1 > n1) ^ i[0];
            e2 = (p2 > n2) ^ i[1];
            chk({port_f_pin2_out, port_f_pin1_out, port_f_pin2_oe,
                 port_f_pin1_oe}, {e2, e1, 2'b11});
            apb(0, `DCC_OFS_CTRL, 8'h00);
            chk(rd, {24'h000000, e2, e1, i[1:0], 4'h3});
        end
        // Change flag with global enable off, then the full chain
        apb(1, `DCC_OFS_ENA, 8'h40);
        apb(1, `DCC_OFS_INTCTL, 8'h40);
        apb(1, `DCC_OFS_REQ, 8'h00);
        n1 <= 8'h80;
        p1 <= (p1 > n1) ? 8'h00 : 8'hFF;
        repeat (5) @(posedge pclk);
        chk({compare_irq_request, wake_request}, 2'b01);
        apb(1, `DCC_OFS_REQ, 8'h00);
        apb(0, `DCC_OFS_REQ, 8'h00);
        chk(rd, 32'h00000040);
        apb(1, `DCC_OFS_INTCTL, 8'hC0);
        @(posedge pclk);
        chk(compare_irq_request, 1'b1);
        // Bench keeps its own copy of the status bits to see what changed
        apb(0, `DCC_OFS_CTRL, 8'h00);
        chk(rd, {24'h000000, e2, ~e1, 6'h33});
        apb(1, `DCC_OFS_REQ, 8'h00);
        apb(0, `DCC_OFS_REQ, 8'h00);
        chk({rd[7:0], compare_irq_request}, 9'h000);
        apb(1, `DCC_OFS_REQ, 8'h40);
        apb(0, `DCC_OFS_REQ, 8'h00);
        chk(rd, 32'h00000040);
        // Multiplexed mode with both switch settings, then off; the
        // change interrupt is disabled around mode changes
        apb(1, `DCC_OFS_ENA, 8'h00);
        apb(1, `DCC_OFS_CTRL, 8'h0E);
        @(posedge pclk);
        chk({compare_enable, ref_to_positive, neg_input_switch}, 4'hF);
        apb(1, `DCC_OFS_CTRL, 8'h06);
        @(posedge pclk);
        chk({ref_to_positive, neg_input_switch}, 2'b10);
        apb(1, `DCC_OFS_CTRL, 8'h07);
        @(posedge pclk);
        chk(compare_enable, 2'b00);
        port_f_in <= 8'($urandom);
        analog_pin_mask <= 8'($urandom);
        repeat (3) @(posedge pclk);
        apb(0, `DCC_OFS_PORT, 8'h00);
        chk(rd, {24'h000000, port_f_in & ~analog_pin_mask});
        complete_run;
    end
endmodule
bind dcc_top dcc_properties i_chk (.pclk, .presetn, .psel, .penable,
    .prdata, .pready, .pslverr, .first_compare_raw, .port_f_pin1_out,
    .port_f_pin1_oe, .compare_enable, .ref_to_positive,
    .neg_input_switch, .compare_irq_request, .wake_request);
`default_nettype wire
